// *** shared/ref_alarm_pkg.sv ***
// constants for the reference input alarm status bank
// assumes a 32-bit axi4-lite slave, one register per aligned word
package ref_alarm_pkg;
  // printed offsets are register indices; byte address is index * 4
  localparam logic [7:0] IDX_ALARM_IN1_IN2 = 8'h11;
  localparam logic [7:0] IDX_ALARM_IN3 = 8'h13;
  localparam logic [7:0] IDX_ALARM_IN4 = 8'h14;
  localparam logic [7:0] IDX_VALID_LOWER = 8'h20;
  localparam logic [7:0] IDX_VALID_UPPER = 8'h21;
  localparam logic [7:0] IDX_TEST_MODE = 8'h30;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h32;
  localparam logic [7:0] IDX_THR_GENERAL = 8'h49;
  localparam logic [7:0] IDX_THR_SELECTED = 8'h4A;
  localparam logic [7:0] IDX_SELECTED = 8'h4B;
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] ALARM_RESET = 8'h66;
  localparam logic [7:0] VALID_RESET = 8'h00;
  localparam logic [7:0] THR_RESET = 8'h00;
  // nibble bit positions
  localparam int BIT_SOFT = 3;
  localparam int BIT_HARD = 2;
  localparam int BIT_NOACT = 1;
  localparam int BIT_PLOCK = 0;
  // validity bit positions
  localparam int VLD_IN1 = 2;
  localparam int VLD_IN2 = 3;
  localparam int VLD_IN3 = 7;
  localparam int VLD_IN4 = 0;
  localparam int NUM_INPUTS = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int LOCK_TIMEOUT_S = 100;
  localparam longint CLK_HZ = 10000000;
endpackage

// *** verilog/ref_input_alarm_status.sv ***
// reference input alarm/validity status bank with axi4-lite slave
// assumes monitors deliver synchronous per-input levels and a deviation code
//
// Function
// (R1) input 4 validity in upper byte bit 0
// (R2) upper validity byte bits 7:1 zero, resets zero
// (R3) inputs 3,2,1 validity at lower bits 7,3,2
// (R4) nibble: soft 3, hard 2, noact 1, lock 0
// (R5) soft alarm does not invalidate input
// (R6) hard alarm invalidates input
// (R7) soft threshold: general or selected upper nibble
// (R8) hard threshold: general or selected lower nibble
// (R9) no-activity flag follows activity monitor
// (R10) phase lock alarm after 100 s unlocked
// (R11) alarm bytes at 0x11, 0x13, 0x14
// (R12) alarm bytes reset to 0x66; each input nibble resets to 6, so 0x13 reads 0x60 and 0x14 reads 0x06
// (R13) alarm bytes writable only in test mode
// (R14) flags updated together in system clock
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module ref_input_alarm_status
  import ref_alarm_pkg::*;
#(
  parameter longint LOCK_TIMEOUT_CYCLES = longint'(LOCK_TIMEOUT_S) * CLK_HZ,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [NUM_INPUTS-1:0] no_activity,
  input wire logic [4*NUM_INPUTS-1:0] freq_deviation,
  input wire logic dpll_locked,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  // index is 8 bits above the byte lane bits, so the address needs 10 bits
  // the lock counter is 32 bits wide; longer timeouts would wrap
  if (ADDR_W < ADDR_LSB + 8 ||
      LOCK_TIMEOUT_CYCLES < 1 ||
      LOCK_TIMEOUT_CYCLES > 64'hFFFFFFFF) begin : g_bad_params
    $error("ref_input_alarm_status: unsupported parameters");
  end

  typedef struct packed {
    logic [NUM_INPUTS-1:0][3:0] alarm;
    logic [7:0] valid_lo;
    logic [7:0] valid_hi;
    logic test_mode;
    logic [1:0] selected;
    logic [7:0] thr_gen;
    logic [7:0] thr_sel;
    logic [NUM_INPUTS-1:0] irq_status;
    logic [NUM_INPUTS-1:0] irq_mask;
    logic [31:0] lock_count;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    // ready flags kept as flops so every bus output leaves a register
    logic awready;
    logic wready;
    logic arready;
  } state_s;

  state_s r, next_r;
  logic [NUM_INPUTS-1:0] soft_hit, hard_hit;

  // threshold compare per input
  generate
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_thr
      logic [3:0] dev;
      logic [3:0] soft_thr, hard_thr;
      logic is_sel;
      assign dev = freq_deviation[4*i +: 4];
      assign is_sel = (r.selected == 2'(i));
      assign soft_thr = is_sel ? r.thr_sel[7:4] : r.thr_gen[7:4]; // [R7]
      assign hard_thr = is_sel ? r.thr_sel[3:0] : r.thr_gen[3:0]; // [R8]
      assign soft_hit[i] = dev > soft_thr;
      assign hard_hit[i] = dev > hard_thr;
    end
  endgenerate

  function automatic logic [7:0] byte_of(input logic [3:0] hi, input logic [3:0] lo);
    byte_of = {hi, lo};
  endfunction

  always_comb begin
    logic [NUM_INPUTS-1:0][3:0] mon;
    logic [NUM_INPUTS-1:0] vld;
    logic [NUM_INPUTS-1:0] events;
    logic [7:0] idx;
    logic [31:0] rd;
    logic hit;
    logic plock;
    next_r = r;
    mon = r.alarm;
    vld = '0;
    events = '0;
    idx = '0;
    rd = '0;
    hit = 1'b0;
    plock = 1'b0;

    // phase lock timer on the selected source
    if (dpll_locked) begin
      next_r.lock_count = '0;
    end else if (r.lock_count < 32'(LOCK_TIMEOUT_CYCLES)) begin
      next_r.lock_count = r.lock_count + 32'h1;
    end
    plock = !dpll_locked && (r.lock_count >= 32'(LOCK_TIMEOUT_CYCLES)); // [R10]

    // all flags refresh in one edge so reads are coherent [R14]
    for (int i = 0; i < NUM_INPUTS; i++) begin
      mon[i][BIT_SOFT] = soft_hit[i]; // [R4]
      mon[i][BIT_HARD] = hard_hit[i];
      mon[i][BIT_NOACT] = no_activity[i]; // [R9]
      mon[i][BIT_PLOCK] = (r.selected == 2'(i)) && plock; // [R10]
      // soft alarm ignored for validity [R5] [R6]
      vld[i] = !(mon[i][BIT_HARD] || mon[i][BIT_NOACT] || mon[i][BIT_PLOCK]);
      events[i] = |(mon[i] & ~r.alarm[i]);
    end
    // in test mode software owns the alarm bytes; monitors still drive validity and irq
    if (!r.test_mode) begin
      next_r.alarm = mon;
    end
    next_r.valid_lo = '0;
    next_r.valid_lo[VLD_IN3] = vld[2]; // [R3]
    next_r.valid_lo[VLD_IN2] = vld[1];
    next_r.valid_lo[VLD_IN1] = vld[0];
    next_r.valid_hi = {7'h00, vld[3]}; // [R1] [R2]

    // write channel: address and data accepted in either order
    if (s_axi_awvalid && !r.aw_ok) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_idx = s_axi_awaddr[ADDR_LSB +: 8];
    end
    if (s_axi_wvalid && !r.w_ok) begin
      next_r.w_ok = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      hit = r.wstrb[0];
      case (r.aw_idx)
        IDX_ALARM_IN1_IN2: begin // [R11]
          if (r.test_mode && hit) begin
            next_r.alarm[0] = r.wdata[3:0]; // [R13]
            next_r.alarm[1] = r.wdata[7:4];
          end
        end
        IDX_ALARM_IN3: begin
          if (r.test_mode && hit) begin
            next_r.alarm[2] = r.wdata[7:4]; // [R13]
          end
        end
        IDX_ALARM_IN4: begin
          if (r.test_mode && hit) begin
            next_r.alarm[3] = r.wdata[3:0]; // [R13]
          end
        end
        IDX_VALID_LOWER, IDX_VALID_UPPER: begin
        end
        IDX_TEST_MODE: begin
          if (hit) begin
            next_r.test_mode = r.wdata[0];
          end
        end
        IDX_THR_GENERAL: begin
          if (hit) begin
            next_r.thr_gen = r.wdata[7:0];
          end
        end
        IDX_THR_SELECTED: begin
          if (hit) begin
            next_r.thr_sel = r.wdata[7:0];
          end
        end
        IDX_SELECTED: begin
          if (hit) begin
            next_r.selected = r.wdata[1:0];
          end
        end
        IDX_IRQ_MASK: begin
          if (hit) begin
            next_r.irq_mask = r.wdata[NUM_INPUTS-1:0];
          end
        end
        IDX_IRQ_STATUS: begin
          if (hit) begin
            next_r.irq_status = r.irq_status & ~r.wdata[NUM_INPUTS-1:0];
          end
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // new alarm edges set sticky bits; set beats a same-cycle clear
    next_r.irq_status = next_r.irq_status | events;

    // read channel
    if (s_axi_arvalid && !r.rvalid) begin
      idx = s_axi_araddr[ADDR_LSB +: 8];
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (idx)
        IDX_ALARM_IN1_IN2: begin
          rd = {24'h0, byte_of(r.alarm[1], r.alarm[0])};
        end
        IDX_ALARM_IN3: begin
          rd = {24'h0, byte_of(r.alarm[2], 4'h0)};
        end
        IDX_ALARM_IN4: begin
          rd = {24'h0, byte_of(4'h0, r.alarm[3])};
        end
        IDX_VALID_LOWER: begin
          rd = {24'h0, r.valid_lo};
        end
        IDX_VALID_UPPER: begin
          rd = {24'h0, r.valid_hi};
        end
        IDX_TEST_MODE: begin
          rd = {31'h0, r.test_mode};
        end
        IDX_THR_GENERAL: begin
          rd = {24'h0, r.thr_gen};
        end
        IDX_THR_SELECTED: begin
          rd = {24'h0, r.thr_sel};
        end
        IDX_SELECTED: begin
          rd = {30'h0, r.selected};
        end
        IDX_IRQ_STATUS: begin
          rd = {28'h0, r.irq_status};
        end
        IDX_IRQ_MASK: begin
          rd = {28'h0, r.irq_mask};
        end
        default: begin
          next_r.rresp = RESP_SLVERR;
        end
      endcase
      next_r.rdata = rd;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    // ready is the inverse of the held-request flags, taken from next state so both change on the same edge
    next_r.awready = !next_r.aw_ok;
    next_r.wready = !next_r.w_ok;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.alarm <= {NUM_INPUTS{ALARM_RESET[3:0]}}; // [R12]
      r.valid_lo <= VALID_RESET;
      r.valid_hi <= VALID_RESET; // [R2]
      r.thr_gen <= THR_RESET;
      r.thr_sel <= THR_RESET;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;
endmodule

// *** verif/ref_alarm_monitor.sv ***
// checker for the alarm status bank register port
// assumes the top module's ports, a single clock domain
`timescale 1ns/1ps
module ref_alarm_monitor
  import ref_alarm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic ar_ok;
  assign ar_ok = s_axi_arvalid && s_axi_arready;
  chk_r_latency: assert property (ar_ok |=> s_axi_rvalid) else $error("read answer late");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("aw open");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("b held");
  chk_upper_zero: assert property (ar_ok && s_axi_araddr == {IDX_VALID_UPPER, 2'h0} |=>
    s_axi_rdata[7:1] == 7'h00) else $error("upper validity bits set");
  chk_lower_unused: assert property (ar_ok && s_axi_araddr == {IDX_VALID_LOWER, 2'h0} |=>
    s_axi_rdata[6:4] == 3'h0 && s_axi_rdata[1:0] == 2'h0) else $error("lower unused set");
  chk_in4_nibble: assert property (ar_ok && s_axi_araddr == {IDX_ALARM_IN4, 2'h0} |=>
    s_axi_rdata[7:4] == 4'h0) else $error("input 4 nibble wrong");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// *** verif/ref_input_alarm_status_tb.sv ***
// bench for the alarm status bank, axi4-lite master in tasks
// assumes lock timeout shortened to 20 cycles
`timescale 1ns/1ps
module ref_input_alarm_status_tb;
  import ref_alarm_pkg::*;
  typedef struct packed {logic [3:0] na; logic [15:0] fd; logic [39:0] e;} row_s;
  logic clk_sys = 0, reset = 1, dpll_locked = 1;
  logic [3:0] no_activity = 4'h0;
  logic [15:0] freq_deviation = 16'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  int error_cnt = 0, n_checks = 0;
  // each row: alarm 11/13/14, validity lower/upper
  row_s rows [3] = '{'{4'h0, 16'h0000, 40'h0000008C01},
    '{4'h0, 16'h0952, 40'h88C0000C01}, '{4'hA, 16'h0003, 40'h2C00028000}};
  logic [7:0] ix [5] = '{IDX_ALARM_IN1_IN2, IDX_ALARM_IN3, IDX_ALARM_IN4,
    IDX_VALID_LOWER, IDX_VALID_UPPER};
  ref_input_alarm_status #(.LOCK_TIMEOUT_CYCLES(20)) dut (.clk_sys, .reset, .no_activity,
    .freq_deviation, .dpll_locked, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a = 1, w = 1;
    @(posedge clk_sys);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (a | w) begin
      @(posedge clk_sys);
      a = a && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    rb = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clk_sys);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    // late rready so the slave must hold its answer
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge clk_sys);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rv, {24'h0, e});
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 0;
    wr(IDX_IRQ_MASK, 8'h0F);
    wr(IDX_THR_GENERAL, 8'h48);
    wr(IDX_THR_SELECTED, 8'h12);
    wr(IDX_IRQ_STATUS, 8'h0F);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      no_activity <= rows[i].na;
      freq_deviation <= rows[i].fd;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 5; k++) rc(ix[k], rows[i].e[39-8*k -: 8]);
    end
    chk({31'h0, irq}, 32'h1);
    rc(IDX_IRQ_STATUS, 8'h0F);
    no_activity <= 4'h0;
    freq_deviation <= 16'h0;
    wr(IDX_IRQ_STATUS, 8'h0F);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    dpll_locked <= 0;
    repeat (30) @(posedge clk_sys);
    rc(IDX_ALARM_IN1_IN2, 8'h01);
    rc(IDX_VALID_LOWER, 8'h88);
    dpll_locked <= 1;
    wr(IDX_SELECTED, 8'h03);
    dpll_locked <= 0;
    repeat (30) @(posedge clk_sys);
    rc(IDX_ALARM_IN4, 8'h01);
    rc(IDX_ALARM_IN1_IN2, 8'h00);
    dpll_locked <= 1;
    wr(IDX_ALARM_IN1_IN2, 8'hFF);
    rc(IDX_ALARM_IN1_IN2, 8'h00);
    wr(IDX_TEST_MODE, 8'h01);
    wr(IDX_ALARM_IN1_IN2, 8'hA5);
    rc(IDX_ALARM_IN1_IN2, 8'hA5);
    chk({30'h0, rb}, {30'h0, RESP_OKAY});
    reset <= 1;
    repeat (2) @(posedge clk_sys);
    chk({28'h0, s_axi_awready, s_axi_arready, s_axi_rvalid, irq}, 32'hC);
    reset <= 0;
    rc(IDX_TEST_MODE, 8'h00);
    rc(IDX_ALARM_IN1_IN2, 8'h00);
    rc(IDX_VALID_UPPER, 8'h01);
    wr(8'hFF, 8'h00);
    chk({30'h0, rb}, {30'h0, RESP_SLVERR});
    rd(8'hFF);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    finish_test;
  end
endmodule
bind ref_input_alarm_status ref_alarm_monitor #(.ADDR_W(ADDR_W)) mon (.clk_sys, .reset,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .irq);
